// [rtl/merl_pkg.sv]
// Package of constants for the module error and lock address registers.
//
// Contract
// - Any set module error bit also raises the summary error flag, bus error bit 18.
// - Arbitration drop flag, bit 10, sets when a winner drives no command.
// - Arbitration drop captures that cycle's bus command and address.
// - Arbitration collision flag, bit 9, sets on a request in an illegal slot.
// - Cache data double error flag, bit 8, sets on uncorrectable unload data.
// - Cache data single error flag, bit 7, sets on single-bit unload error.
// - Either data error captures address and syndrome.
// - Cache map parity flag, bit 6, sets on map parity error; address captured.
// - Cache status parity flag, bit 5, sets on status RAM parity error.
// - Cache tag parity flag, bit 4, sets on tag RAM parity error.
// - Tag/status errors: probe captures command address; miss sets status bit 0, fill address.
// - Processor-map parity field, bits 3:0, one per map RAM; address captured.
// - Lock register holds latest load-locked memory address and a valid bit.
// - Lock valid bit 31 stays set until a bus write hits the 64-byte block or a one is written to it.
// - Lock valid bit decides store-conditional success.
// - A bus write to the locked block clears the lock valid bit.
// - Lock address field bits 28:1 holds physical address bits 33:6.
// - With lockout mode nonzero, count failures; assert lockout after 1, 8, 16 or 32.
package merl_pkg;
  localparam logic [11:0] MERL_MERR_OFF      = 12'hc40;
  localparam logic [11:0] MERL_LOCK_OFF      = 12'hc80;
  localparam logic [11:0] MERL_MODE_OFF      = 12'hc00;
  localparam int          MERL_ARBITRATION_DROP_FLAG_BIT   = 10;
  localparam int          MERL_ARBITRATION_COLLISION_FLAG_BIT    = 9;
  localparam int          MERL_DBE_BIT       = 8;
  localparam int          MERL_SBE_BIT       = 7;
  localparam int          MERL_MAP_BIT       = 6;
  localparam int          MERL_STAT_BIT      = 5;
  localparam int          MERL_TAG_BIT       = 4;
  localparam int          MERL_ERR_W         = 11;
  localparam int          MERL_SUMMARY_BIT   = 18;
  localparam int          MERL_LOCK_BIT      = 31;
  localparam int          MERL_LOCKED_BLOCK_ADDRESS_LO       = 1;
  localparam int          MERL_LOCKED_BLOCK_ADDRESS_HI       = 28;
  localparam int          MERL_PA_W          = 34;
  localparam int          MERL_TO_LO         = 8;
  localparam int          MERL_LMODE_LO      = 6;
  localparam logic [10:0] MERL_ERR_RST       = 11'h000;
  localparam logic [27:0] MERL_LOCKED_BLOCK_ADDRESS_RST      = 28'h0000000;
  localparam logic [5:0]  MERL_TH_1          = 6'h01;
  localparam logic [5:0]  MERL_TH_8          = 6'h08;
  localparam logic [5:0]  MERL_TH_16         = 6'h10;
  localparam logic [5:0]  MERL_TH_32         = 6'h20;
  typedef enum logic [1:0] {
    MERL_TO_1  = 2'b00,
    MERL_TO_8  = 2'b01,
    MERL_TO_16 = 2'b10,
    MERL_TO_32 = 2'b11
  } merl_to_t;
endpackage

// [rtl/merl_regs.sv]
// Module error register, lock address register and lockout counter.
//
// The plain strobed port is this design's own decision.
`default_nettype none
module merl_regs (
  // Clock and reset.
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // Register port.
  input  wire logic [11:0]                   reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  // Bus error events and bus cycle data.
  input  wire logic                          arb_drop_evt,
  input  wire logic                          arb_col_evt,
  input  wire logic [31:0]                   bus_cmd_addr,
  input  wire logic                          bus_wr_evt,
  input  wire logic [merl_pkg::MERL_PA_W-1:0] bus_wr_pa,
  // Cache error events.
  input  wire logic                          data_dbe_evt,
  input  wire logic                          data_sbe_evt,
  input  wire logic [31:0]                   data_err_addr,
  input  wire logic [7:0]                    data_syndrome,
  input  wire logic                          map_pe_evt,
  input  wire logic                          stat_pe_evt,
  input  wire logic                          tag_pe_evt,
  input  wire logic                          pe_from_miss,
  input  wire logic [3:0]                    pmap_pe_evt,
  input  wire logic [31:0]                   pe_addr,
  // Processor lock traffic.
  input  wire logic                          ld_lock_evt,
  input  wire logic [merl_pkg::MERL_PA_W-1:0] ld_lock_pa,
  input  wire logic                          st_cond_evt,
  // Results.
  output logic                               st_cond_ok,
  output logic                               node_specific_error_summary,
  output logic                               biu_fill_err_r,
  output logic      [31:0]                   error_command_capture_r,
  output logic      [7:0]                    error_syndrome_capture_r,
  output logic      [31:0]                   fill_addr_r,
  output logic                               bus_lockout_r
);
  import merl_pkg::*;

  logic [MERL_ERR_W-1:0] err_r;
  logic [MERL_ERR_W-1:0] err_set;
  logic                  lock_r;
  logic [27:0]           locked_block_address_r;
  logic [1:0]            lmode_r;
  logic [1:0]            to_r;
  logic [5:0]            fail_r;
  logic [5:0]            thresh;
  logic                  wr_merr;
  logic                  wr_lock;
  logic                  lock_hit;
  logic                  sc_fail;

  assign wr_merr = reg_wr && (reg_addr == MERL_MERR_OFF);
  assign wr_lock = reg_wr && (reg_addr == MERL_LOCK_OFF);

  always_comb begin
    err_set                   = '0;
    err_set[MERL_ARBITRATION_DROP_FLAG_BIT] = arb_drop_evt;
    err_set[MERL_ARBITRATION_COLLISION_FLAG_BIT]  = arb_col_evt;
    err_set[MERL_DBE_BIT]     = data_dbe_evt;
    err_set[MERL_SBE_BIT]     = data_sbe_evt;
    err_set[MERL_MAP_BIT]     = map_pe_evt;
    err_set[MERL_STAT_BIT]    = stat_pe_evt;
    err_set[MERL_TAG_BIT]     = tag_pe_evt;
    err_set[3:0]              = pmap_pe_evt;
  end

  // A new event in the clearing cycle survives, so no error is ever lost.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      err_r <= MERL_ERR_RST;
    end else if (wr_merr) begin
      err_r <= (err_r & ~reg_wdata[MERL_ERR_W-1:0]) | err_set;
    end else begin
      err_r <= err_r | err_set;
    end
  end

  assign node_specific_error_summary = |err_r;

  // Earlier sources in this chain take priority when several fire together.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      error_command_capture_r  <= 32'h00000000;
      error_syndrome_capture_r <= 8'h00;
      fill_addr_r              <= 32'h00000000;
      biu_fill_err_r           <= 1'b0;
    end else begin
      if (arb_drop_evt) begin
        error_command_capture_r <= bus_cmd_addr;
      end else if (data_dbe_evt || data_sbe_evt) begin
        error_command_capture_r  <= data_err_addr;
        error_syndrome_capture_r <= data_syndrome;
      end else if (map_pe_evt || (|pmap_pe_evt)) begin
        error_command_capture_r <= pe_addr;
      end else if ((tag_pe_evt || stat_pe_evt) && !pe_from_miss) begin
        error_command_capture_r <= pe_addr;
      end
      if ((tag_pe_evt || stat_pe_evt) && pe_from_miss) begin
        biu_fill_err_r <= 1'b1;
        fill_addr_r    <= pe_addr;
      end
    end
  end

  assign lock_hit = bus_wr_evt && (bus_wr_pa[MERL_PA_W-1:6] == locked_block_address_r);

  // A load-locked in the same cycle as a clearing write wins: it is newer.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lock_r <= 1'b0;
      locked_block_address_r <= MERL_LOCKED_BLOCK_ADDRESS_RST;
    end else if (ld_lock_evt) begin
      lock_r <= 1'b1;
      locked_block_address_r <= ld_lock_pa[MERL_PA_W-1:6];
    end else if (lock_hit || (wr_lock && reg_wdata[MERL_LOCK_BIT])) begin
      lock_r <= 1'b0;
    end
  end

  assign st_cond_ok = lock_r;
  assign sc_fail    = st_cond_evt && !lock_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lmode_r <= 2'b00;
      to_r    <= 2'b00;
    end else if (reg_wr && (reg_addr == MERL_MODE_OFF)) begin
      lmode_r <= reg_wdata[MERL_LMODE_LO +: 2];
      to_r    <= reg_wdata[MERL_TO_LO +: 2];
    end
  end

  always_comb begin
    case (merl_to_t'(to_r))
      MERL_TO_1:  thresh = MERL_TH_1;
      MERL_TO_8:  thresh = MERL_TH_8;
      MERL_TO_16: thresh = MERL_TH_16;
      default:    thresh = MERL_TH_32;
    endcase
  end

  // Lockout holds until a store-conditional succeeds or the mode is turned off.
  always_ff @(posedge clock) begin
    if (sys_rst || lmode_r == 2'b00) begin
      fail_r        <= 6'h00;
      bus_lockout_r <= 1'b0;
    end else if (st_cond_evt && lock_r) begin
      fail_r        <= 6'h00;
      bus_lockout_r <= 1'b0;
    end else if (sc_fail) begin
      if (fail_r + 6'h01 >= thresh) begin
        bus_lockout_r <= 1'b1;
      end
      if (fail_r != MERL_TH_32) begin
        fail_r <= fail_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == MERL_MERR_OFF) begin
        reg_rdata <= {21'h0, err_r};
      end else if (reg_addr == MERL_LOCK_OFF) begin
        reg_rdata <= {lock_r, 2'b00, locked_block_address_r, 1'b0};
      end else if (reg_addr == MERL_MODE_OFF) begin
        reg_rdata <= {22'h0, to_r, lmode_r, 6'h00};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  summary_a: assert property (@(posedge clock) disable iff (sys_rst)
    (|err_r) |-> node_specific_error_summary) else $error("summary flag missing");
  drop_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    arb_drop_evt |=> err_r[MERL_ARBITRATION_DROP_FLAG_BIT]) else $error("drop flag not set");
  drop_cap_a: assert property (@(posedge clock) disable iff (sys_rst)
    arb_drop_evt |=> error_command_capture_r == $past(bus_cmd_addr))
    else $error("drop capture wrong");
  col_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    arb_col_evt |=> err_r[MERL_ARBITRATION_COLLISION_FLAG_BIT]) else $error("collision flag not set");
  w1c_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_merr && reg_wdata[MERL_SBE_BIT] && !data_sbe_evt) |=> !err_r[MERL_SBE_BIT])
    else $error("flag not cleared");
  miss_fill_a: assert property (@(posedge clock) disable iff (sys_rst)
    ((tag_pe_evt || stat_pe_evt) && pe_from_miss) |=>
    biu_fill_err_r && fill_addr_r == $past(pe_addr))
    else $error("miss capture wrong");
  lock_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    ld_lock_evt |=> lock_r && locked_block_address_r == $past(ld_lock_pa[MERL_PA_W-1:6]))
    else $error("lock not loaded");
  lock_hit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (lock_hit && !ld_lock_evt) |=> !lock_r) else $error("lock not cleared");
  sc_lockout_a: assert property (@(posedge clock) disable iff (sys_rst)
    (lmode_r != 2'b00 && sc_fail && (fail_r + 6'h01 >= thresh)) |=> bus_lockout_r)
    else $error("lockout missing");
endmodule
`default_nettype wire

// [verif/merl_far_model.sv]
// Far-side model: processor lock traffic and bus writes from other nodes.
`default_nettype none
module merl_far_model (
  // Clock.
  input  wire logic                           clock,
  // Lock traffic toward the block.
  output logic                                ld_lock_evt,
  output logic [merl_pkg::MERL_PA_W-1:0]      ld_lock_pa,
  output logic                                st_cond_evt,
  output logic                                bus_wr_evt,
  output logic [merl_pkg::MERL_PA_W-1:0]      bus_wr_pa
);
  timeunit 1ns;
  timeprecision 1ns;
  import merl_pkg::*;
  initial begin
    {ld_lock_evt, st_cond_evt, bus_wr_evt} = 3'h0;
    ld_lock_pa = '0;
    bus_wr_pa = '0;
  end
  // Released address lines show the inverse, so a stale value never looks like a hit.
  task automatic load_locked(input logic [MERL_PA_W-1:0] pa);
    @(posedge clock);
    ld_lock_evt <= 1'b1;
    ld_lock_pa <= pa;
    @(posedge clock);
    ld_lock_evt <= 1'b0;
    ld_lock_pa <= ~pa;
    #1;
  endtask
  task automatic bus_write(input logic [MERL_PA_W-1:0] pa);
    @(posedge clock);
    bus_wr_evt <= 1'b1;
    bus_wr_pa <= pa;
    @(posedge clock);
    bus_wr_evt <= 1'b0;
    bus_wr_pa <= ~pa;
    #1;
  endtask
  task automatic store_cond();
    @(posedge clock);
    st_cond_evt <= 1'b1;
    @(posedge clock);
    st_cond_evt <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// [verif/test_module_error_and_lock_regs.sv]
// Self-checking bench for the module error and lock address registers.
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_module_error_and_lock_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import merl_pkg::*;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [10:0] ev = '0;
  logic        pe_from_miss = 1'b0;
  logic [31:0] cmd_a = 32'h1111_0000;
  logic [31:0] dat_a = 32'h2222_0000;
  logic [31:0] pe_a = 32'h3333_0000;
  logic [7:0]  syn = 8'h5a;
  logic [31:0] reg_rdata, ecap, fadr;
  logic [7:0]  scap;
  logic        ld_e, st_e, bw_e, st_ok, summ, fill_err, lockout;
  logic [33:0] ld_pa, bw_pa;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] d;
  logic [33:0] pa;
  merl_far_model far (.clock(clock), .ld_lock_evt(ld_e), .ld_lock_pa(ld_pa), .st_cond_evt(st_e),
    .bus_wr_evt(bw_e), .bus_wr_pa(bw_pa));
  merl_regs DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arb_drop_evt(ev[10]),
    .arb_col_evt(ev[9]), .bus_cmd_addr(cmd_a), .bus_wr_evt(bw_e), .bus_wr_pa(bw_pa),
    .data_dbe_evt(ev[8]), .data_sbe_evt(ev[7]), .data_err_addr(dat_a),
    .data_syndrome(syn), .map_pe_evt(ev[6]), .stat_pe_evt(ev[5]), .tag_pe_evt(ev[4]),
    .pe_from_miss(pe_from_miss), .pmap_pe_evt(ev[3:0]), .pe_addr(pe_a),
    .ld_lock_evt(ld_e), .ld_lock_pa(ld_pa), .st_cond_evt(st_e), .st_cond_ok(st_ok),
    .node_specific_error_summary(summ), .biu_fill_err_r(fill_err), .error_command_capture_r(ecap),
    .error_syndrome_capture_r(scap), .fill_addr_r(fadr), .bus_lockout_r(lockout));
  initial begin
    forever #5 clock = ~clock;
  end
  // The ceiling leaves ample room over the few hundred cycles the tests need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= '0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic pulse(input logic [10:0] v);
    @(posedge clock);
    ev <= v;
    @(posedge clock);
    ev <= '0;
    #1;
  endtask
  task automatic test_errors();
    for (int i = 0; i < MERL_ERR_W; i++) begin
      pulse(11'h001 << i);
      rd(MERL_MERR_OFF, d);
      `CHK("err bit", 32'h1 << i, d)
      `CHK("summary", 1'b1, summ)
      `CHK("capture", i == 10 ? 32'h1111_0000 : (i > 6 ? 32'h2222_0000 : 32'h3333_0000), ecap)
      if (i == 7 || i == 8) `CHK("syndrome", 8'h5a, scap)
      wr(MERL_MERR_OFF, 32'h0);
      rd(MERL_MERR_OFF, d);
      `CHK("hold", 32'h1 << i, d)
      wr(MERL_MERR_OFF, 32'h1 << i);
      rd(MERL_MERR_OFF, d);
      `CHK("clear", 32'h0, d)
      `CHK("summary off", 1'b0, summ)
    end
    pe_from_miss <= 1'b1;
    pe_a <= 32'h4444_0000;
    pulse(11'h010);
    `CHK("fill err", 1'b1, fill_err)
    `CHK("fill addr", 32'h4444_0000, fadr)
    `CHK("miss no capture", 32'h1111_0000, ecap)
    wr(MERL_MERR_OFF, 32'h010);
    $display("test errors done");
  endtask
  task automatic test_lock();
    pa = 34'h2_1234_5680;
    far.load_locked(pa);
    rd(MERL_LOCK_OFF, d);
    `CHK("lock reg", {1'b1, 2'b00, pa[33:6], 1'b0}, d)
    `CHK("sc ok", 1'b1, st_ok)
    far.bus_write(34'h2_1234_56c0);
    `CHK("other block", 1'b1, st_ok)
    far.bus_write(34'h2_1234_56bf);
    `CHK("same block", 1'b0, st_ok)
    far.load_locked(34'h0_0000_0040);
    wr(MERL_LOCK_OFF, 32'h0000_0000);
    `CHK("w0 lock", 1'b1, st_ok)
    wr(MERL_LOCK_OFF, 32'h8000_0000);
    rd(MERL_LOCK_OFF, d);
    `CHK("w1c lock", {3'b000, 28'h0000001, 1'b0}, d)
    $display("test lock done");
  endtask
  task automatic test_lockout();
    wr(MERL_MODE_OFF, 32'h0000_0140);
    rd(MERL_MODE_OFF, d);
    `CHK("mode", 32'h0000_0140, d)
    for (int i = 1; i <= 8; i++) begin
      far.store_cond();
      @(posedge clock);
      #1 `CHK("lockout", i == 8, lockout)
    end
    $display("test lockout done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd(MERL_MERR_OFF, d);
    `CHK("err reset", 32'h0, d)
    rd(MERL_LOCK_OFF, d);
    `CHK("lock reset", 32'h0, d)
    test_errors();
    test_lock();
    test_lockout();
    complete_run();
  end
endmodule
`default_nettype wire
